// ===== hw/i2sb_pkg.sv
// Shared constants and types of the I2C slave buffer port
package i2sb_pkg;
  localparam logic [6:0]  GC_ADDR        = 7'h00;
  localparam logic [6:0]  ID_ADDR        = 7'h7C;
  localparam logic [6:0]  DEF_SLAVE_ADDR = 7'h22;
  localparam logic [7:0]  CMD_SRST       = 8'h06;
  localparam logic [7:0]  CMD_FLUSH      = 8'h0E;
  localparam logic [7:0]  CMD_DAVAIL     = 8'h0C;
  localparam logic [7:0]  CMD_USBST      = 8'h16;
  localparam logic [7:0]  USB_SUSP       = 8'h00;
  localparam logic [7:0]  USB_DEFAULT    = 8'h01;
  localparam logic [7:0]  USB_ADDRESSED  = 8'h02;
  localparam logic [7:0]  USB_CONFIGURED = 8'h03;
  localparam logic [7:0]  CNT_SAT        = 8'hFF;
  localparam logic [7:0]  NO_DATA        = 8'hFF;
  // Identity values are arbitrary
  localparam logic [11:0] MAKER_ID       = 12'hA5C;
  localparam logic [8:0]  PART_ID        = 9'h1B3;
  localparam logic [2:0]  REV_ID         = 3'h1;
  localparam logic [23:0] ID_WORD        = {MAKER_ID, PART_ID, REV_ID};
  localparam logic [1:0]  ID_LAST        = 2'h2;
  localparam int          BUF_WIDTH      = 8;
  localparam logic [1:0]  BUF_FULL       = 2'h2;
  localparam logic [3:0]  CFG_LAST       = 4'hF;
  localparam logic [3:0]  CFG_ADDR_IDX   = 4'h0;
  localparam logic [3:0]  CFG_OPT_IDX    = 4'h1;
  localparam int          CFG_PD_BIT     = 0;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_RX    = 3'b010,
    S_ACK   = 3'b011,
    S_TX    = 3'b100,
    S_TXACK = 3'b101,
    S_WAIT  = 3'b110
  } i2sb_bus_t;

  typedef enum logic [1:0] {
    M_DATA  = 2'b00,
    M_COUNT = 2'b01,
    M_STATE = 2'b10,
    M_ID    = 2'b11
  } i2sb_mode_t;
endpackage

// ===== hw/i2sb_buf.sv
// Two-entry byte buffer with valid/ready on both sides and flush
`timescale 1ns/10ps
`default_nettype none
module i2sb_buf (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          flush,
  input  wire logic [i2sb_pkg::BUF_WIDTH-1:0] inData,
  input  wire logic                          inValid,
  output logic                               inReady,
  output logic      [i2sb_pkg::BUF_WIDTH-1:0] outData,
  output logic                               outValid,
  input  wire logic                          outReady,
  output logic      [1:0]                    count
);
  import i2sb_pkg::*;

  typedef struct packed {
    logic [1:0][BUF_WIDTH-1:0] mem;
    logic                      wr;
    logic                      rd;
    logic [1:0]                cnt;
    logic                      inRdy;
    logic                      outVld;
    logic [BUF_WIDTH-1:0]      head;
  } i2sb_buf_t;

  i2sb_buf_t st_ff, nxt_st;
  logic push, pop;

  always_comb begin
    nxt_st = st_ff;
    push   = inValid & st_ff.inRdy;
    pop    = st_ff.outVld & outReady;
    if (push) begin
      nxt_st.mem[st_ff.wr] = inData;
      nxt_st.wr            = ~st_ff.wr;
    end
    if (pop) begin
      nxt_st.rd = ~st_ff.rd;
    end
    nxt_st.cnt = 2'(st_ff.cnt + {1'b0, push} - {1'b0, pop});
    // Flush beats a same-cycle push: the word is dropped
    if (flush) begin
      nxt_st.cnt = 2'h0;
      nxt_st.wr  = 1'b0;
      nxt_st.rd  = 1'b0;
    end
    nxt_st.inRdy  = (nxt_st.cnt != BUF_FULL);
    nxt_st.outVld = (nxt_st.cnt != 2'h0);
    nxt_st.head   = nxt_st.mem[nxt_st.rd];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.inRdy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign inReady  = st_ff.inRdy;
  assign outValid = st_ff.outVld;
  assign outData  = st_ff.head;
  assign count    = st_ff.cnt;
endmodule // i2sb_buf
`default_nettype wire

// ===== hw/i2sb_port.sv
// I2C slave front end with receive/transmit buffers and command decoding
//
// How it works
// - Receive-space pin low whenever the receive buffer has a free byte.
// - Write address is NACKed when the receive buffer has no room.
// - Burst write bytes are ACKed when stored, NACKed when buffer full.
// - General call command 0x06 soft-resets and empties all buffers.
// - General call command 0x0E flushes transmit and receive buffers.
// - General call command 0x0C makes next read return transmit byte count.
// - General call command 0x16 makes next read return the USB state code.
// - State codes: 0 suspended, 1 default, 2 addressed, 3 configured.
// - Identity answer is three bytes: 12-bit maker, 9-bit part, 3-bit revision.
// - Master ends identity read with NACK; further ACKs wrap the three bytes.
// - After reset or USB bus reset the configuration memory is scanned and loaded.
// - Sleep output is low during USB suspend.
// - Power enable low once configured, high during suspend.
// - Stay-awake input held low blocks suspend, even when unplugged.
// - Bus-power detect input tells whether USB bus power is present.
// - Optional pull-down of interface lines during suspend, off by default.
// - General call address is ACKed and its command byte interpreted.
// - Read address is NACKed when the transmit buffer is empty and no count or state request is pending.
// - Byte count saturates at 0xFF.
`timescale 1ns/10ps
`default_nettype none
module i2sb_port (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [7:0]      rxData,
  output logic            rxValid,
  input  wire logic       rxReady,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic [1:0] usbState,
  input  wire logic       usbSuspendReq,
  input  wire logic       usbBusReset,
  input  wire logic       busPowerDetect,
  input  wire logic       stayAwakeN,
  output logic [3:0]      cfgAddr,
  input  wire logic [7:0] cfgData,
  output logic            cfgBusy,
  output logic            rxSpaceAvailN,
  output logic            txDataAvailN,
  output logic            sleepN,
  output logic            powerEnableN,
  output logic            ioPullDown
);
  import i2sb_pkg::*;

  typedef struct packed {
    logic       sclS1, sclS2, sclP, sdaS1, sdaS2, sdaP;
    logic       pwrS1, pwrS2, awkS1, awkS2;
    i2sb_bus_t  bus;
    i2sb_bus_t  ackTo;
    i2sb_mode_t mode;
    i2sb_mode_t pendMode;
    logic       pendValid;
    logic [2:0] bitCnt;
    logic       byteDone;
    logic [7:0] sh;
    logic       gc, idPhase, idArmed;
    logic [1:0] idIdx;
    logic       sdaOe, sdaOut;
    logic       rxPushV;
    logic [7:0] rxPushD;
    logic       txPop, flush;
    logic       loading, cfgVldD;
    logic [3:0] cfgAddr, cfgIdxD;
    logic [6:0] slave;
    logic       pdOpt;
    logic       rxSpN, txAvN, sleepN, pwrEnN, pullDn;
  } i2sb_port_t;

  i2sb_port_t st_ff, nxt_st;
  logic       rxInRdy, rxOutVld, txOutVld;
  logic [7:0] rxHead, txHead, ld;
  logic [1:0] txCnt;
  logic       rise, fall, startC, stopC, susp, load;

  function automatic logic [7:0] satCount(input logic [9:0] c);
    return (c > 10'h0FF) ? CNT_SAT : c[7:0];
  endfunction

  function automatic logic [7:0] idByte(input logic [1:0] i);
    return ID_WORD[8'(23 - 8 * i) -: 8];
  endfunction

  i2sb_buf u_rx (
    .clock    (clock),
    .rst      (rst),
    .flush    (st_ff.flush),
    .inData   (st_ff.rxPushD),
    .inValid  (st_ff.rxPushV),
    .inReady  (rxInRdy),
    .outData  (rxHead),
    .outValid (rxOutVld),
    .outReady (rxReady),
    .count    ()
  );

  i2sb_buf u_tx (
    .clock    (clock),
    .rst      (rst),
    .flush    (st_ff.flush),
    .inData   (txData),
    .inValid  (txValid),
    .inReady  (txReady),
    .outData  (txHead),
    .outValid (txOutVld),
    .outReady (st_ff.txPop),
    .count    (txCnt)
  );

  always_comb begin
    nxt_st = st_ff;
    load   = 1'b0;
    nxt_st.sclS1 = sclIn;
    nxt_st.sclS2 = st_ff.sclS1;
    nxt_st.sclP  = st_ff.sclS2;
    nxt_st.sdaS1 = sdaIn;
    nxt_st.sdaS2 = st_ff.sdaS1;
    nxt_st.sdaP  = st_ff.sdaS2;
    nxt_st.pwrS1 = busPowerDetect;
    nxt_st.pwrS2 = st_ff.pwrS1;
    nxt_st.awkS1 = stayAwakeN;
    nxt_st.awkS2 = st_ff.awkS1;
    nxt_st.rxPushV = 1'b0;
    nxt_st.txPop   = 1'b0;
    nxt_st.flush   = 1'b0;
    rise   = st_ff.sclS2 & ~st_ff.sclP;
    fall   = ~st_ff.sclS2 & st_ff.sclP;
    startC = st_ff.sclS2 & st_ff.sclP & st_ff.sdaP & ~st_ff.sdaS2;
    stopC  = st_ff.sclS2 & st_ff.sclP & ~st_ff.sdaP & st_ff.sdaS2;
    // Suspend only with no stay-awake request; lost bus power also suspends
    susp   = (usbSuspendReq | ~st_ff.pwrS2) & st_ff.awkS2;
    case (st_ff.mode)
      M_DATA:  ld = txOutVld ? txHead : NO_DATA;
      M_COUNT: ld = satCount({8'h00, txCnt});
      M_STATE: ld = susp ? USB_SUSP : {6'h00, usbState};
      M_ID:    ld = idByte(st_ff.idIdx);
      default: ld = NO_DATA;
    endcase

    if (startC) begin
      nxt_st.bus      = S_ADDR;
      nxt_st.bitCnt   = 3'h0;
      nxt_st.byteDone = 1'b0;
      nxt_st.sdaOe    = 1'b0;
    end else if (stopC) begin
      nxt_st.bus   = S_IDLE;
      nxt_st.sdaOe = 1'b0;
    end else begin
      case (st_ff.bus)
        S_ADDR, S_RX: begin
          if (rise) begin
            nxt_st.sh       = {st_ff.sh[6:0], st_ff.sdaS2};
            nxt_st.bitCnt   = 3'(st_ff.bitCnt + 3'h1);
            nxt_st.byteDone = (st_ff.bitCnt == 3'h7);
          end else if (fall && st_ff.byteDone) begin
            nxt_st.byteDone = 1'b0;
            nxt_st.bus      = S_ACK;
            nxt_st.ackTo    = S_RX;
            nxt_st.sdaOe    = 1'b1;
            if (st_ff.bus == S_ADDR) begin
              nxt_st.gc      = 1'b0;
              nxt_st.idPhase = 1'b0;
              if (st_ff.loading) begin
                nxt_st.bus   = S_WAIT;
                nxt_st.sdaOe = 1'b0;
              end else if (st_ff.sh == {GC_ADDR, 1'b0}) begin
                nxt_st.gc = 1'b1;
              end else if (st_ff.sh == {ID_ADDR, 1'b0}) begin
                nxt_st.idPhase = 1'b1;
              end else if (st_ff.sh == {ID_ADDR, 1'b1} && st_ff.idArmed) begin
                nxt_st.mode    = M_ID;
                nxt_st.idIdx   = 2'h0;
                nxt_st.idArmed = 1'b0;
                nxt_st.ackTo   = S_TX;
              end else if (st_ff.sh == {st_ff.slave, 1'b0}) begin
                if (!rxInRdy) begin
                  nxt_st.bus   = S_WAIT;
                  nxt_st.sdaOe = 1'b0;
                end
              end else if (st_ff.sh == {st_ff.slave, 1'b1}) begin
                nxt_st.ackTo = S_TX;
                if (st_ff.pendValid) begin
                  nxt_st.mode      = st_ff.pendMode;
                  nxt_st.pendValid = 1'b0;
                end else if (txOutVld) begin
                  nxt_st.mode = M_DATA;
                end else begin
                  nxt_st.bus   = S_WAIT;
                  nxt_st.sdaOe = 1'b0;
                end
              end else begin
                nxt_st.bus   = S_WAIT;
                nxt_st.sdaOe = 1'b0;
              end
            end else if (st_ff.gc) begin
              // One command per general call; later bytes go unanswered
              nxt_st.ackTo = S_WAIT;
              case (st_ff.sh)
                CMD_SRST: begin
                  nxt_st.flush     = 1'b1;
                  nxt_st.pendValid = 1'b0;
                  nxt_st.idArmed   = 1'b0;
                end
                CMD_FLUSH: nxt_st.flush = 1'b1;
                CMD_DAVAIL: begin
                  nxt_st.pendValid = 1'b1;
                  nxt_st.pendMode  = M_COUNT;
                end
                CMD_USBST: begin
                  nxt_st.pendValid = 1'b1;
                  nxt_st.pendMode  = M_STATE;
                end
                default: nxt_st.ackTo = S_WAIT;
              endcase
            end else if (st_ff.idPhase) begin
              nxt_st.ackTo   = S_WAIT;
              nxt_st.idArmed = (st_ff.sh[7:1] == st_ff.slave);
            end else if (rxInRdy) begin
              nxt_st.rxPushV = 1'b1;
              nxt_st.rxPushD = st_ff.sh;
            end else begin
              nxt_st.sdaOe = 1'b0;
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            nxt_st.bus    = st_ff.ackTo;
            nxt_st.bitCnt = 3'h0;
            nxt_st.sdaOe  = 1'b0;
            if (st_ff.ackTo == S_TX) begin
              load         = 1'b1;
              nxt_st.sdaOe = ~ld[7];
            end
          end
        end
        S_TX: begin
          if (rise) begin
            nxt_st.bitCnt   = 3'(st_ff.bitCnt + 3'h1);
            nxt_st.byteDone = (st_ff.bitCnt == 3'h7);
          end else if (fall) begin
            if (st_ff.byteDone) begin
              nxt_st.byteDone = 1'b0;
              nxt_st.sdaOe    = 1'b0;
              nxt_st.bus      = S_TXACK;
            end else begin
              nxt_st.sh    = {st_ff.sh[6:0], 1'b0};
              nxt_st.sdaOe = ~st_ff.sh[6];
            end
          end
        end
        S_TXACK: begin
          if (rise) begin
            if (st_ff.sdaS2) begin
              nxt_st.bus = S_WAIT;
            end else begin
              nxt_st.byteDone = 1'b1;
              load            = 1'b1;
            end
          end else if (fall && st_ff.byteDone) begin
            nxt_st.byteDone = 1'b0;
            nxt_st.bus      = S_TX;
            nxt_st.bitCnt   = 3'h0;
            nxt_st.sdaOe    = ~st_ff.sh[7];
          end
        end
        default: nxt_st.sdaOe = 1'b0;
      endcase
    end

    if (load) begin
      nxt_st.sh    = ld;
      nxt_st.txPop = (st_ff.mode == M_DATA) & txOutVld;
      if (st_ff.mode == M_ID) begin
        nxt_st.idIdx = (st_ff.idIdx == ID_LAST) ? 2'h0 : 2'(st_ff.idIdx + 2'h1);
      end
    end

    // Memory answers one cycle after its address
    nxt_st.cfgVldD = st_ff.loading;
    nxt_st.cfgIdxD = st_ff.cfgAddr;
    if (st_ff.cfgVldD) begin
      if (st_ff.cfgIdxD == CFG_ADDR_IDX) nxt_st.slave = cfgData[6:0];
      if (st_ff.cfgIdxD == CFG_OPT_IDX) nxt_st.pdOpt = cfgData[CFG_PD_BIT];
    end
    if (st_ff.loading) begin
      nxt_st.cfgAddr = 4'(st_ff.cfgAddr + 4'h1);
      nxt_st.loading = (st_ff.cfgAddr != CFG_LAST);
    end
    if (usbBusReset) begin
      nxt_st.loading = 1'b1;
      nxt_st.cfgAddr = 4'h0;
    end

    nxt_st.rxSpN  = ~rxInRdy;
    nxt_st.txAvN  = ~txOutVld;
    nxt_st.sleepN = ~susp;
    nxt_st.pwrEnN = susp | ({6'h00, usbState} != USB_CONFIGURED);
    nxt_st.pullDn = susp & st_ff.pdOpt;
    nxt_st.sdaOut = 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff         <= '0;
      st_ff.sclS1   <= 1'b1;
      st_ff.sclS2   <= 1'b1;
      st_ff.sclP    <= 1'b1;
      st_ff.sdaS1   <= 1'b1;
      st_ff.sdaS2   <= 1'b1;
      st_ff.sdaP    <= 1'b1;
      st_ff.awkS1   <= 1'b1;
      st_ff.awkS2   <= 1'b1;
      st_ff.loading <= 1'b1;
      st_ff.slave   <= DEF_SLAVE_ADDR;
      st_ff.txAvN   <= 1'b1;
      st_ff.sleepN  <= 1'b1;
      st_ff.pwrEnN  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sdaOut        = st_ff.sdaOut;
  assign sdaOe         = st_ff.sdaOe;
  assign rxData        = rxHead;
  assign rxValid       = rxOutVld;
  assign cfgAddr       = st_ff.cfgAddr;
  assign cfgBusy       = st_ff.loading;
  assign rxSpaceAvailN = st_ff.rxSpN;
  assign txDataAvailN  = st_ff.txAvN;
  assign sleepN        = st_ff.sleepN;
  assign powerEnableN  = st_ff.pwrEnN;
  assign ioPullDown    = st_ff.pullDn;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic decAddr, decRx;
  assign decAddr = fall && st_ff.byteDone && st_ff.bus == S_ADDR && !startC && !stopC && !st_ff.loading;
  assign decRx   = fall && st_ff.byteDone && st_ff.bus == S_RX && !startC && !stopC;

  a_rx_space_pin: assert property (rxInRdy |=> !rxSpaceAvailN)
    else $error("space pin not low with free room");
  a_addr_wr_nack: assert property (decAddr && st_ff.sh == {st_ff.slave, 1'b0} && !rxInRdy
    |=> !sdaOe && st_ff.bus == S_WAIT) else $error("write address acked with full buffer");
  a_data_nack_full: assert property (decRx && !st_ff.gc && !st_ff.idPhase && !rxInRdy
    |=> !sdaOe && !st_ff.rxPushV) else $error("byte acked without room");
  a_data_ack_push: assert property (decRx && !st_ff.gc && !st_ff.idPhase && rxInRdy
    |=> sdaOe && st_ff.rxPushV) else $error("stored byte not acked");
  a_flush_empties: assert property (decRx && st_ff.gc && (st_ff.sh == CMD_SRST || st_ff.sh == CMD_FLUSH)
    |=> st_ff.flush ##1 !rxValid) else $error("flush left data");
  a_rd_nack_empty: assert property (decAddr && st_ff.sh == {st_ff.slave, 1'b1} && !st_ff.pendValid && !txOutVld
    |=> !sdaOe && st_ff.bus == S_WAIT) else $error("read acked with empty buffer");
  a_pend_count: assert property (decRx && st_ff.gc && st_ff.sh == CMD_DAVAIL
    |=> st_ff.pendValid && st_ff.pendMode == M_COUNT) else $error("count request lost");
  a_id_wrap: assert property (load && st_ff.mode == M_ID && st_ff.idIdx == ID_LAST
    |=> st_ff.idIdx == 2'h0) else $error("identity index did not wrap");
  a_stay_awake: assert property (!st_ff.awkS2 |=> sleepN)
    else $error("suspended while kept awake");
  a_suspend_pins: assert property (susp |=> powerEnableN && !sleepN)
    else $error("suspend pins wrong");

  c_gc_flush: cover property (decRx && st_ff.gc && st_ff.sh == CMD_FLUSH);
  c_id_read: cover property (load && st_ff.mode == M_ID && st_ff.idIdx == ID_LAST);
  c_wr_ack: cover property (decRx && rxInRdy && !st_ff.gc);
  c_rd_data: cover property (load && st_ff.mode == M_DATA && txOutVld);
endmodule // i2sb_port
`default_nettype wire

// ===== test/i2sb_master_model.sv
// I2C master model that drives the bus toward the slave port
`timescale 1ns/10ps
`default_nettype none
module i2sb_master_model (
  input  wire logic clock,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaRel
);
  // Quarter bit of 2 clocks gives a 160 ns SCL; slave answers 3 clocks after a fall
  localparam int Q = 2;
  initial begin
    sclOut = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic qw(input int n);
    repeat (n * Q) @(negedge clock);
  endtask
  // Data moves a quarter after SCL falls, so no false start or stop
  task automatic bitIo(input logic b, output logic s);
    qw(1);
    sdaRel = b;
    qw(1);
    sclOut = 1'b1;
    qw(1);
    s = sdaLine;
    qw(1);
    sclOut = 1'b0;
  endtask
  task automatic start();
    qw(1);
    sdaRel = 1'b1;
    qw(1);
    sclOut = 1'b1;
    qw(2);
    sdaRel = 1'b0;
    qw(2);
    sclOut = 1'b0;
  endtask
  task automatic stop();
    qw(1);
    sdaRel = 1'b0;
    qw(1);
    sclOut = 1'b1;
    qw(2);
    sdaRel = 1'b1;
    qw(2);
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(b[i], s);
    bitIo(1'b1, s);
    ack = ~s;
  endtask
  task automatic recvByte(input logic mAck, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
    bitIo(~mAck, s);
  endtask
endmodule // i2sb_master_model
`default_nettype wire

// ===== test/tb_i2sb_port.sv
// Self-checking bench of the I2C slave buffer port
`timescale 1ns/10ps
`default_nettype none
module tb_i2sb_port;
  import i2sb_pkg::*;
  localparam logic [6:0] MY_ADDR = 7'h31;
  logic       clock = 1'b0, rst = 1'b1, sdaOut, sdaOe, rxValid, rxReady, txValid, txReady;
  logic       usbSuspendReq, usbBusReset, busPowerDetect, stayAwakeN, cfgBusy, optBit;
  logic       rxSpaceAvailN, txDataAvailN, sleepN, powerEnableN, ioPullDown, sclIn, sdaRel;
  logic [7:0] rxData, txData, cfgData;
  logic [3:0] cfgAddr, lastAddr = 4'h0;
  logic [1:0] usbState;
  wire        sdaLine = sdaRel & ~sdaOe;
  int         num_errors = 0, compares = 0;
  logic [23:0] idWord = {MAKER_ID, PART_ID, REV_ID};
  logic [7:0] cmds [3] = '{8'h55, CMD_FLUSH, CMD_SRST};
  logic       keep [3] = '{1'b1, 1'b0, 1'b0};

  always #10 clock = ~clock;
  // Memory answers for the address of the previous cycle, as the port expects
  always @(negedge clock) begin
    lastAddr <= cfgAddr;
    cfgData <= (lastAddr == 4'h0) ? {1'b0, MY_ADDR} : (lastAddr == 4'h1) ? {7'h00, optBit} : 8'h00;
  end

  i2sb_master_model m (.clock(clock), .sdaLine(sdaLine), .sclOut(sclIn), .sdaRel(sdaRel));
  i2sb_port dut (.clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
    .txValid(txValid), .txReady(txReady), .usbState(usbState), .usbSuspendReq(usbSuspendReq),
    .usbBusReset(usbBusReset), .busPowerDetect(busPowerDetect), .stayAwakeN(stayAwakeN),
    .cfgAddr(cfgAddr), .cfgData(cfgData), .cfgBusy(cfgBusy), .rxSpaceAvailN(rxSpaceAvailN),
    .txDataAvailN(txDataAvailN), .sleepN(sleepN), .powerEnableN(powerEnableN),
    .ioPullDown(ioPullDown));

  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string s);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic addr(input logic [6:0] a, input logic rw, input logic exp, input string s);
    logic ack;
    m.start();
    m.sendByte({a, rw}, ack);
    check(ack, exp, s);
  endtask
  task automatic wrB(input logic [7:0] b, input logic exp);
    logic ack;
    m.sendByte(b, ack);
    check(ack, exp, "data ack");
  endtask
  task automatic rdB(input logic mAck, input logic [7:0] exp, input string s);
    logic [7:0] b;
    m.recvByte(mAck, b);
    check(b, exp, s);
  endtask
  task automatic gc(input logic [7:0] cmd);
    addr(GC_ADDR, 1'b0, 1'b1, "general call address");
    wrB(cmd, 1'b1);
    m.stop();
  endtask
  // Ready is registered, so a ready seen here still holds at the next edge
  task automatic pushTx(input logic [7:0] d);
    for (int i = 0; i < 20 && txReady !== 1'b1; i++) @(negedge clock);
    txData = d;
    txValid = 1'b1;
    @(negedge clock);
    txValid = 1'b0;
    @(negedge clock);
  endtask
  task automatic popRx(input logic [7:0] exp);
    for (int i = 0; i < 50 && rxValid !== 1'b1; i++) @(negedge clock);
    check(rxData, exp, "receive data");
    rxReady = 1'b1;
    @(negedge clock);
    rxReady = 1'b0;
    @(negedge clock);
  endtask
  task automatic waitCfg();
    settle(2);
    for (int i = 0; i < 40 && cfgBusy !== 1'b0; i++) @(negedge clock);
    check(cfgBusy, 1'b0, "config load ends");
  endtask

  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    wrap_up();
  end

  initial begin
    {rxReady, txValid, usbSuspendReq, usbBusReset, optBit} = '0;
    {busPowerDetect, stayAwakeN} = 2'b11;
    txData = 8'h00;
    usbState = 2'h3;
    settle(8);
    check(rxSpaceAvailN, 1'b0, "rx space in reset");
    check(sdaOut, 1'b0, "open-drain data level");
    rst = 1'b0;
    waitCfg();
    addr(MY_ADDR, 1'b0, 1'b1, "write address");
    wrB(8'hA1, 1'b1);
    wrB(8'h5E, 1'b1);
    wrB(8'hC3, 1'b0);
    m.stop();
    check(rxSpaceAvailN, 1'b1, "rx full");
    addr(MY_ADDR, 1'b0, 1'b0, "write address when full");
    m.stop();
    addr(DEF_SLAVE_ADDR, 1'b0, 1'b0, "old default address");
    m.stop();
    popRx(8'hA1);
    popRx(8'h5E);
    settle(3);
    check(rxSpaceAvailN, 1'b0, "rx space after drain");
    $display("Test write flow done");
    addr(MY_ADDR, 1'b1, 1'b0, "read address when empty");
    m.stop();
    pushTx(8'h3C);
    pushTx(8'h96);
    settle(3);
    check(txDataAvailN, 1'b0, "tx has data");
    check(txReady, 1'b0, "tx buffer full");
    gc(CMD_DAVAIL);
    addr(MY_ADDR, 1'b1, 1'b1, "count read address");
    rdB(1'b0, 8'h02, "available count");
    m.stop();
    addr(MY_ADDR, 1'b1, 1'b1, "data read address");
    rdB(1'b1, 8'h3C, "tx byte 0");
    rdB(1'b0, 8'h96, "tx byte 1");
    m.stop();
    settle(3);
    check(txDataAvailN, 1'b1, "tx empty after read");
    $display("Test read flow done");
    for (int s = 0; s < 4; s++) begin
      usbState = s[1:0];
      gc(CMD_USBST);
      addr(MY_ADDR, 1'b1, 1'b1, "state read address");
      rdB(1'b0, {6'h00, s[1:0]}, "usb state code");
      m.stop();
    end
    usbState = 2'h3;
    $display("Test usb state done");
    for (int k = 0; k < 3; k++) begin
      addr(MY_ADDR, 1'b0, 1'b1, "write address");
      wrB(8'h70, 1'b1);
      m.stop();
      pushTx(8'h81);
      gc(cmds[k]);
      settle(4);
      check(rxValid, keep[k], "rx contents after command");
      check(txDataAvailN, !keep[k], "tx contents after command");
      if (keep[k]) begin
        popRx(8'h70);
        addr(MY_ADDR, 1'b1, 1'b1, "read kept byte");
        rdB(1'b0, 8'h81, "kept tx byte");
        m.stop();
      end
    end
    $display("Test commands done");
    addr(ID_ADDR, 1'b0, 1'b1, "identity write");
    wrB({MY_ADDR, 1'b1}, 1'b1);
    addr(ID_ADDR, 1'b1, 1'b1, "identity read");
    for (int i = 0; i < 6; i++) rdB(i < 5, idWord[23 - 8 * (i % 3) -: 8], "identity byte");
    m.stop();
    $display("Test identity done");
    settle(8);
    check(sleepN, 1'b1, "awake");
    check(powerEnableN, 1'b0, "power on when configured");
    usbSuspendReq = 1'b1;
    settle(8);
    check(sleepN, 1'b0, "sleep in suspend");
    check(powerEnableN, 1'b1, "power off in suspend");
    check(ioPullDown, 1'b0, "pull-down option off");
    stayAwakeN = 1'b0;
    settle(8);
    check(sleepN, 1'b1, "stay awake");
    {stayAwakeN, usbSuspendReq, busPowerDetect} = 3'b100;
    settle(8);
    check(sleepN, 1'b0, "no bus power");
    optBit = 1'b1;
    usbBusReset = 1'b1;
    settle(1);
    usbBusReset = 1'b0;
    waitCfg();
    settle(8);
    check(ioPullDown, 1'b1, "pull-down option on");
    $display("Test suspend done");
    wrap_up();
  end
endmodule // tb_i2sb_port
`default_nettype wire
